/* File: inc/spi_instr_pkg.sv */
/*
 * Shared constants and types of the serial peripheral test instrument:
 * register offsets, status field positions, host commands, transfer states
 * and the register access carrier.
 * Assumes the instrument network presents one register access per clock.
 */
package spi_instr_pkg;

    // Register offsets on the instrument access port
    localparam int unsigned ADDR_W          = 3;
    localparam logic [2:0]  OFS_IDENTIFIER  = 3'h0;
    localparam logic [2:0]  OFS_SCRATCH     = 3'h1;
    localparam logic [2:0]  OFS_DIVIDER     = 3'h2;
    localparam logic [2:0]  OFS_TARGET_IDX  = 3'h3;
    localparam logic [2:0]  OFS_OUTBOUND    = 3'h4;
    localparam logic [2:0]  OFS_INBOUND     = 3'h5;
    localparam logic [2:0]  OFS_LENGTH      = 3'h6;
    localparam logic [2:0]  OFS_COMPLETION  = 3'h7;

    // Completion register field position
    localparam int unsigned DONE_BIT        = 0;

    // Reset value of every host-visible register except the identifier
    localparam logic [7:0]  REG_RESET_VALUE = 8'h00;

    // Synthesis defaults
    localparam int unsigned DATA_WIDTH_DEF  = 8;
    localparam int unsigned DATA_WIDTH_MIN  = 8;
    localparam int unsigned TARGET_CNT_DEF  = 1;

    // Commands presented by the instrument network, held as a level
    typedef enum logic [1:0] {
        CMD_RUN   = 2'h0,
        CMD_STOP  = 2'h1,
        CMD_RESET = 2'h2
    } cmd_t;

    // Transfer sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_SHIFT = 3'h2,
        ST_TAIL  = 3'h4
    } xfer_state_t;

    // One register access request
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
    } reg_req_t;

endpackage : spi_instr_pkg

/* File: rtl/sclk_tick_gen.sv */
/*
 * Half-period tick generator for the serial clock.
 * Assumes enable_in comes from logic on the same clock; the counter restarts
 * whenever enable_in is low.
 */
module sclk_tick_gen #(
    parameter int unsigned WIDTH = spi_instr_pkg::DATA_WIDTH_DEF
) (
    input  wire logic             ref_clk_in,
    input  wire logic             reset_in,
    input  wire logic             enable_in,
    input  wire logic [WIDTH-1:0] divisor_in,
    output logic                  tick_out
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } div_state_t;

    div_state_t state_q;
    div_state_t state_d;

    // One tick every divisor+1 clocks, so a full period is 2*(divisor+1)
    assign tick_out = enable_in && (state_q.count == divisor_in);

    always_comb begin
        state_d = state_q;
        if (!enable_in || tick_out) begin
            state_d.count = '0;
        end else begin
            state_d.count = state_q.count + WIDTH'(1);
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

endmodule : sclk_tick_gen

/* File: rtl/spi_test_master.sv */
/*
 * Serial peripheral master test instrument: register bank reached through
 * the instrument access port, transfer sequencer and serial pins.
 * Assumes register accesses and commands arrive from logic on ref_clk_in;
 * the serial data input is a pin and is synchronised here.
 * The data input lags two clocks behind the pin, so dividers of two and up
 * leave room to sample it; smaller dividers suit only slow targets.
 * A shift length above the word width is a host fault and is not guarded.
 * A target index with no matching select runs the frame with none asserted.
 * Commands other than run leave every register write unapplied.
 */
//
// Behaviour
// - Serial clock period equals 2*(divider+1) system clocks.
// - Writing a non-zero shift length starts a transfer.
// - Completion bit 0 reads one after transfer end, zero meanwhile.
// - Stop command abandons activity and returns to idle.
// - A change of presented command clears a completion flag set in an earlier cycle.
// - Reset command zeroes the host registers and returns the sequencer to idle.
// - Master drives every frame, shifting out and sampling in together.
// - Word width parameter, minimum eight, sizes data path and registers.
// - Number of target selects equals a target count parameter.
// - Parameter chooses active-high or active-low target selects.
// - Parameters fix serial clock idle level and sampling phase.
// - Target index register picks the one select asserted during transfer.
// - Outbound word register supplies bits shifted out next transfer.
// - Inbound word register holds bits captured in last completed transfer.
// - Scratch register reads back exactly what was written.
module spi_test_master #(
    parameter int unsigned   DATA_WIDTH       = spi_instr_pkg::DATA_WIDTH_DEF,
    parameter int unsigned   TARGET_COUNT     = spi_instr_pkg::TARGET_CNT_DEF,
    parameter bit            SELECT_ACT_HIGH  = 1'b0,
    parameter bit            CLOCK_IDLE_LEVEL = 1'b0,
    parameter bit            CLOCK_PHASE      = 1'b0,
    // Identification value is arbitrary
    parameter logic [7:0]    INSTR_ID         = 8'h5a
) (
    input  wire logic                          ref_clk_in,
    input  wire logic                          reset_in,
    input  wire spi_instr_pkg::cmd_t           cmd_in,
    input  wire spi_instr_pkg::reg_req_t       reg_req_in,
    input  wire logic [DATA_WIDTH-1:0]         reg_wdata_in,
    output logic      [DATA_WIDTH-1:0]         reg_rdata_out,
    input  wire logic                          miso_in,
    output logic                               mosi_out,
    output logic                               sclk_out,
    output logic      [TARGET_COUNT-1:0]       target_select_out
);

    localparam int unsigned W = DATA_WIDTH;
    localparam int unsigned N = TARGET_COUNT;
    // Phase zero captures on the leading edge, phase one on the trailing edge
    localparam bit          CAPTURE_LEADING = !CLOCK_PHASE;

    // Whole module state in one record
    typedef struct packed {
        logic [W-1:0]                scratch;
        logic [W-1:0]                divider;
        logic [W-1:0]                target_index;
        logic [W-1:0]                outbound;
        logic [W-1:0]                inbound;
        logic [W-1:0]                length;
        logic                        done;
        logic [W-1:0]                tx;
        logic [W-1:0]                rx;
        logic [W-1:0]                bits_left;
        logic                        sclk_lvl;
        logic                        mosi;
        logic [N-1:0]                select;
        logic [1:0]                  miso_sync;
        spi_instr_pkg::cmd_t         cmd_prev;
        spi_instr_pkg::xfer_state_t  state;
        logic [W-1:0]                rdata;
    } master_state_t;

    // Contents after reset_in and under the reset command
    localparam master_state_t RESET_STATE = '{
        scratch:      W'(spi_instr_pkg::REG_RESET_VALUE),
        divider:      W'(spi_instr_pkg::REG_RESET_VALUE),
        target_index: W'(spi_instr_pkg::REG_RESET_VALUE),
        outbound:     W'(spi_instr_pkg::REG_RESET_VALUE),
        inbound:      W'(spi_instr_pkg::REG_RESET_VALUE),
        length:       W'(spi_instr_pkg::REG_RESET_VALUE),
        done:         1'b0,
        tx:           '0,
        rx:           '0,
        bits_left:    '0,
        sclk_lvl:     1'b0,
        mosi:         1'b0,
        select:       '0,
        miso_sync:    2'h0,
        cmd_prev:     spi_instr_pkg::CMD_RUN,
        state:        spi_instr_pkg::ST_IDLE,
        rdata:        W'(spi_instr_pkg::REG_RESET_VALUE)
    };

    master_state_t state_q;
    master_state_t state_d;

    logic          tick;
    logic          busy;
    logic          run_cmd;
    logic          start;
    logic          sample_bit;
    logic          length_write;
    logic          cmd_changed;
    logic          last_bit;

    // Word width checked against the eight bit minimum at elaboration
    if (W < spi_instr_pkg::DATA_WIDTH_MIN) begin : g_width_check
        $error("data width below the eight bit register minimum");
    end

    // Index to one-hot select, no select for an index out of range
    function automatic logic [N-1:0] decode_target(input logic [W-1:0] index);
        logic [N-1:0] vec;
        vec = '0;
        for (int unsigned i = 0; i < N; i++) begin
            if (index == W'(i)) begin
                vec[i] = 1'b1;
            end
        end
        return vec;
    endfunction : decode_target

    // Capture one serial bit at the bottom of the receive word
    function automatic logic [W-1:0] shift_in(input logic [W-1:0] word,
                                              input logic         bit_in);
        return {word[W-2:0], bit_in};
    endfunction : shift_in

    // Left-align the programmed length so its top bit leaves first
    function automatic logic [W-1:0] align_tx(input logic [W-1:0] word,
                                              input logic [W-1:0] length);
        return word << (W'(W) - length);
    endfunction : align_tx

    // Serial pins at rest: clock idle, selects released, data low
    function automatic master_state_t park_pins(input master_state_t s);
        master_state_t p;
        p          = s;
        p.sclk_lvl = 1'b0;
        p.mosi     = 1'b0;
        p.select   = '0;
        return p;
    endfunction : park_pins

    // Read multiplexer; write-only registers read as zero
    function automatic logic [W-1:0] read_reg(input master_state_t s,
                                              input logic [2:0]    addr);
        logic [W-1:0] val;
        val = '0;
        case (addr)
            spi_instr_pkg::OFS_IDENTIFIER: begin
                val = W'(INSTR_ID);
            end
            spi_instr_pkg::OFS_SCRATCH: begin
                val = s.scratch;
            end
            spi_instr_pkg::OFS_DIVIDER: begin
                val = s.divider;
            end
            spi_instr_pkg::OFS_INBOUND: begin
                val = s.inbound;
            end
            spi_instr_pkg::OFS_LENGTH: begin
                val = s.length;
            end
            spi_instr_pkg::OFS_COMPLETION: begin
                val[spi_instr_pkg::DONE_BIT] = s.done;
            end
            default: begin
                val = '0;
            end
        endcase
        return val;
    endfunction : read_reg

    // Host register writes; read-only offsets are left untouched
    function automatic master_state_t apply_write(input master_state_t s,
                                                  input logic [2:0]    addr,
                                                  input logic [W-1:0]  data);
        master_state_t n;
        n = s;
        case (addr)
            spi_instr_pkg::OFS_SCRATCH: begin
                n.scratch = data;
            end
            spi_instr_pkg::OFS_DIVIDER: begin
                n.divider = data;
            end
            spi_instr_pkg::OFS_TARGET_IDX: begin
                n.target_index = data;
            end
            spi_instr_pkg::OFS_OUTBOUND: begin
                n.outbound = data;
            end
            spi_instr_pkg::OFS_LENGTH: begin
                n.length = data;
            end
            default: begin
                n = s;
            end
        endcase
        return n;
    endfunction : apply_write

    assign busy    = (state_q.state != spi_instr_pkg::ST_IDLE);
    assign run_cmd = (cmd_in == spi_instr_pkg::CMD_RUN);

    // A length write taken under the run command
    assign length_write = run_cmd && reg_req_in.write
                          && (reg_req_in.addr == spi_instr_pkg::OFS_LENGTH);
    // Start on a non-zero length write while idle
    assign start        = length_write && (reg_wdata_in != '0) && !busy;
    // Any new command level, whichever it is
    assign cmd_changed  = (cmd_in != state_q.cmd_prev);
    // Within the final programmed bit period, both half periods
    assign last_bit     = (state_q.bits_left == W'(1));

    // Second synchroniser stage only
    assign sample_bit = state_q.miso_sync[1];

    sclk_tick_gen #(
        .WIDTH      (W)
    ) u_tick (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .enable_in  (busy),
        .divisor_in (state_q.divider),
        .tick_out   (tick)
    );

    always_comb begin
        state_d = state_q;

        state_d.miso_sync = {state_q.miso_sync[0], miso_in};
        state_d.rdata     = read_reg(state_q, reg_req_in.addr);
        state_d.cmd_prev  = cmd_in;

        if (cmd_changed) begin
            state_d.done = 1'b0;
        end

        // Register writes
        if (reg_req_in.write && run_cmd) begin
            state_d = apply_write(state_d, reg_req_in.addr, reg_wdata_in);
        end

        case (state_q.state)
            spi_instr_pkg::ST_IDLE: begin
                state_d = park_pins(state_d);
                if (start) begin
                    state_d.tx        = align_tx(state_q.outbound,
                                                 reg_wdata_in);
                    state_d.rx        = '0;
                    state_d.bits_left = reg_wdata_in;
                    state_d.select    = decode_target(state_q.target_index);
                    state_d.done      = 1'b0;
                    state_d.state     = spi_instr_pkg::ST_SHIFT;
                    if (!CLOCK_PHASE) begin
                        state_d.mosi = state_d.tx[W-1];
                    end
                end
            end

            spi_instr_pkg::ST_SHIFT: begin
                if (tick) begin
                    state_d.sclk_lvl = !state_q.sclk_lvl;
                    if (!state_q.sclk_lvl) begin
                        // Leading edge
                        if (CAPTURE_LEADING) begin
                            state_d.rx = shift_in(state_q.rx, sample_bit);
                        end else begin
                            state_d.mosi = state_q.tx[W-1];
                            state_d.tx   = state_q.tx << 1;
                        end
                    end else begin
                        // Trailing edge closes one bit period
                        if (!CAPTURE_LEADING) begin
                            state_d.rx = shift_in(state_q.rx, sample_bit);
                        end
                        state_d.bits_left = state_q.bits_left - W'(1);
                        if (last_bit) begin
                            state_d.state = spi_instr_pkg::ST_TAIL;
                        end else if (!CLOCK_PHASE) begin
                            state_d.tx   = state_q.tx << 1;
                            state_d.mosi = state_q.tx[W-2];
                        end
                    end
                end
            end

            spi_instr_pkg::ST_TAIL: begin
                // Hold select one half period after the last edge
                if (tick) begin
                    state_d         = park_pins(state_d);
                    state_d.inbound = state_q.rx;
                    state_d.done    = 1'b1;
                    state_d.state   = spi_instr_pkg::ST_IDLE;
                end
            end

            default: begin
                state_d.state = spi_instr_pkg::ST_IDLE;
            end
        endcase

        // Stop abandons the frame; a done set this cycle still stands
        if (cmd_in == spi_instr_pkg::CMD_STOP) begin
            state_d.state    = spi_instr_pkg::ST_IDLE;
            state_d          = park_pins(state_d);
        end

        // Reset command restores the reset contents, keeping change tracking and the synchroniser
        if (cmd_in == spi_instr_pkg::CMD_RESET) begin
            state_d              = RESET_STATE;
            state_d.cmd_prev     = cmd_in;
            state_d.miso_sync    = {state_q.miso_sync[0], miso_in};
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= RESET_STATE;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata_out = state_q.rdata;
    assign mosi_out      = state_q.mosi;
    // Internal clock level is zero at rest; polarity applied at the pin
    assign sclk_out      = state_q.sclk_lvl ^ CLOCK_IDLE_LEVEL;
    // Internal select is active high; polarity applied at the pin
    assign target_select_out = SELECT_ACT_HIGH ? state_q.select
                                               : ~state_q.select;

endmodule : spi_test_master

/* File: verif/spi_test_master_asserts.sv */
/* Port-level assertions for the serial test master.
   Assumes clock phase 0 and a target index below the select count. */
module spi_test_master_asserts #(
    parameter int unsigned DATA_WIDTH       = 8,
    parameter int unsigned TARGET_COUNT     = 1,
    parameter bit          SELECT_ACT_HIGH  = 1'b0,
    parameter bit          CLOCK_IDLE_LEVEL = 1'b0
) (
    input wire logic                    ref_clk_in,
    input wire logic                    reset_in,
    input wire spi_instr_pkg::cmd_t     cmd_in,
    input wire spi_instr_pkg::reg_req_t reg_req_in,
    input wire logic [DATA_WIDTH-1:0]   reg_wdata_in,
    input wire logic [DATA_WIDTH-1:0]   reg_rdata_out,
    input wire logic                    mosi_out,
    input wire logic                    sclk_out,
    input wire logic [TARGET_COUNT-1:0] target_select_out
);
    logic [TARGET_COUNT-1:0] act;
    logic                    sclk_q;
    logic                    toggle;
    logic [7:0]              run_q;
    logic [7:0]              half_q;

    assign act    = SELECT_ACT_HIGH ? target_select_out : ~target_select_out;
    assign toggle = sclk_out != sclk_q;

    // Cycles since the last serial clock edge or frame start, and the last half period
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sclk_q <= 1'b0;
            run_q  <= 8'hff;
            half_q <= 8'h00;
        end else begin
            sclk_q <= sclk_out;
            run_q  <= (act == '0) ? 8'hff : (toggle ? 8'h00 : run_q + 8'h01);
            half_q <= (act == '0) ? 8'h00 : (toggle ? run_q + 8'h01 : half_q);
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_reset_held;
        (cmd_in == spi_instr_pkg::CMD_RESET) [*3];
    endsequence
    sequence s_start;
        reg_req_in.write && reg_req_in.addr == spi_instr_pkg::OFS_LENGTH
            && reg_wdata_in != '0 && cmd_in == spi_instr_pkg::CMD_RUN && act == '0;
    endsequence

    a_one_select: assert property ($onehot0(act))
        else $error("more than one select asserted");
    a_start_select: assert property (s_start |=> act != '0)
        else $error("length write did not start a frame");
    a_stop_idle: assert property (cmd_in == spi_instr_pkg::CMD_STOP |=>
        act == '0 && sclk_out == CLOCK_IDLE_LEVEL && !mosi_out)
        else $error("stop did not idle the pins");
    a_idle_quiet: assert property (act == '0 && $past(act) == '0 |->
        sclk_out == CLOCK_IDLE_LEVEL && !mosi_out)
        else $error("clock or data active between frames");
    a_reset_zero: assert property (s_reset_held |-> reg_rdata_out == '0
        || $past(reg_req_in.addr) == spi_instr_pkg::OFS_IDENTIFIER)
        else $error("register not zero under reset command");
    a_busy_not_done: assert property (act != '0 && $past(act) != '0
        && $past(reg_req_in.addr) == spi_instr_pkg::OFS_COMPLETION |-> !reg_rdata_out[0])
        else $error("done seen during a frame");
    a_even_halves: assert property (toggle && half_q != 8'h00 |-> run_q + 8'h01 == half_q)
        else $error("serial clock half periods differ");
    a_mosi_trailing: assert property (act != '0 && $past(act) != '0 && $changed(mosi_out)
        |-> $changed(sclk_out) && sclk_out == CLOCK_IDLE_LEVEL)
        else $error("data changed off the trailing edge");
endmodule : spi_test_master_asserts

bind spi_test_master spi_test_master_asserts #(
    .DATA_WIDTH(DATA_WIDTH), .TARGET_COUNT(TARGET_COUNT),
    .SELECT_ACT_HIGH(SELECT_ACT_HIGH), .CLOCK_IDLE_LEVEL(CLOCK_IDLE_LEVEL)
) i_asserts (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .cmd_in(cmd_in),
    .reg_req_in(reg_req_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .mosi_out(mosi_out), .sclk_out(sclk_out), .target_select_out(target_select_out)
);

/* File: verif/spi_target_model.sv */
/* Behavioural serial target, mode 0, active-low select.
   Assumes an eight bit word; released data line shows the inverse. */
module spi_target_model (
    input  wire logic       sclk_in,
    input  wire logic       select_n_in,
    input  wire logic       mosi_in,
    input  wire logic [7:0] reply_in,
    output logic            miso_out,
    output logic [7:0]      heard_out,
    output int              bits_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] shift_q;
    logic       last_q;

    initial begin
        shift_q   = 8'h00;
        last_q    = 1'b0;
        heard_out = 8'h00;
        bits_out  = 0;
    end
    always @(negedge select_n_in) begin
        shift_q   = reply_in;
        heard_out = 8'h00;
        bits_out  = 0;
    end
    always @(posedge select_n_in) last_q = shift_q[7];
    // Capture on the leading edge, present the next bit on the trailing one
    always @(posedge sclk_in) if (!select_n_in) begin
        heard_out = {heard_out[6:0], mosi_in};
        bits_out++;
    end
    always @(negedge sclk_in) if (!select_n_in) shift_q = {shift_q[6:0], 1'b0};
    assign miso_out = select_n_in ? ~last_q : shift_q[7];
endmodule : spi_target_model

/* File: verif/tb.sv */
/* Self-checking bench for the serial test master.
   Assumes the target model sits on select one of two. */
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    clk, rst, miso, mosi, sclk;
    spi_instr_pkg::cmd_t     cmd;
    spi_instr_pkg::reg_req_t req;
    logic [7:0]              wdata, rdata, reply, heard;
    logic [1:0]              tsel;
    int                      bits, bad_count, n_checks;
    time                     t_rise, per;

    spi_test_master #(.TARGET_COUNT(2), .SELECT_ACT_HIGH(1'b0),
        .CLOCK_IDLE_LEVEL(1'b0), .CLOCK_PHASE(1'b0), .INSTR_ID(8'h3c)) i_dut (
        .ref_clk_in(clk), .reset_in(rst), .cmd_in(cmd), .reg_req_in(req),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .miso_in(miso),
        .mosi_out(mosi), .sclk_out(sclk), .target_select_out(tsel));
    spi_target_model i_target (.sclk_in(sclk), .select_n_in(tsel[1]), .mosi_in(mosi),
        .reply_in(reply), .miso_out(miso), .heard_out(heard), .bits_out(bits));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge sclk) begin
        per    = $time - t_rise;
        t_rise = $time;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        req   = '{write: 1'b1, addr: a};
        wdata = d;
        @(negedge clk);
        req.write = 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        req.addr = a;
        @(negedge clk);
        `CHK(rdata, e)
    endtask : rd
    task automatic wait_done;
        for (int i = 0; i < 200 && rdata !== 8'h01; i++) begin
            req.addr = spi_instr_pkg::OFS_COMPLETION;
            @(negedge clk);
        end
        `CHK(rdata, 8'h01)
    endtask : wait_done
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    initial begin
        rst = 1'b1; cmd = spi_instr_pkg::CMD_RUN; req = '0; wdata = 8'h00; reply = 8'h6c;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        for (int a = 0; a < 8; a++) rd(3'(a), (a == 0) ? 8'h3c : 8'h00);
        wr(spi_instr_pkg::OFS_SCRATCH, 8'ha5);
        rd(spi_instr_pkg::OFS_SCRATCH, 8'ha5);
        wr(spi_instr_pkg::OFS_COMPLETION, 8'hff);
        wr(spi_instr_pkg::OFS_INBOUND, 8'hff);
        rd(spi_instr_pkg::OFS_COMPLETION, 8'h00);
        rd(spi_instr_pkg::OFS_INBOUND, 8'h00);
        cmd = spi_instr_pkg::CMD_STOP;
        wr(spi_instr_pkg::OFS_SCRATCH, 8'h77);
        cmd = spi_instr_pkg::CMD_RUN;
        rd(spi_instr_pkg::OFS_SCRATCH, 8'ha5);
        wr(spi_instr_pkg::OFS_DIVIDER, 8'h02);
        wr(spi_instr_pkg::OFS_TARGET_IDX, 8'h01);
        wr(spi_instr_pkg::OFS_OUTBOUND, 8'hb5);
        wr(spi_instr_pkg::OFS_LENGTH, 8'h08);
        rd(spi_instr_pkg::OFS_COMPLETION, 8'h00);
        wait_done;
        rd(spi_instr_pkg::OFS_INBOUND, 8'h6c);
        `CHK(heard, 8'hb5)
        `CHK(bits, 8)
        `CHK(per, 120)
        rd(spi_instr_pkg::OFS_LENGTH, 8'h08);
        reply = 8'ha8;
        wr(spi_instr_pkg::OFS_OUTBOUND, 8'h13);
        wr(spi_instr_pkg::OFS_LENGTH, 8'h05);
        wait_done;
        rd(spi_instr_pkg::OFS_INBOUND, 8'h15);
        `CHK(heard, 8'h13)
        `CHK(bits, 5)
        cmd = spi_instr_pkg::CMD_STOP;
        @(negedge clk);
        rd(spi_instr_pkg::OFS_COMPLETION, 8'h00);
        cmd = spi_instr_pkg::CMD_RUN;
        @(negedge clk);
        wr(spi_instr_pkg::OFS_LENGTH, 8'h08);
        repeat (10) @(negedge clk);
        cmd = spi_instr_pkg::CMD_STOP;
        @(negedge clk);
        `CHK(tsel, 2'b11)
        `CHK(sclk, 1'b0)
        cmd = spi_instr_pkg::CMD_RUN;
        rd(spi_instr_pkg::OFS_INBOUND, 8'h15);
        rd(spi_instr_pkg::OFS_COMPLETION, 8'h00);
        cmd = spi_instr_pkg::CMD_RESET;
        repeat (3) @(negedge clk);
        cmd = spi_instr_pkg::CMD_RUN;
        rd(spi_instr_pkg::OFS_SCRATCH, 8'h00);
        rd(spi_instr_pkg::OFS_DIVIDER, 8'h00);
        rd(spi_instr_pkg::OFS_LENGTH, 8'h00);
        conclude;
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        conclude;
    end
endmodule : tb
